/* hdl/pie_expander.sv */
// Peripheral interrupt expander: latches requests, drives core levels, answers acknowledges.
// Assumes synchronous inputs, one clock, and an AXI4-Lite master for the registers.
//
// The AXI4-Lite register port and the register addresses were left to the implementer.
`include "pie_cfg.svh"

module pie_expander import pie_pkg::*; (
	// Clock, reset, enable
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic i_clk_en,
	// Peripheral side
	input wire pie_req_type i_req,
	input wire pie_present_type i_present,
	// CPU side
	input wire logic i_ack,
	input wire pie_level_type i_ack_level,
	output pie_cpu_lines_type o_cpu_lines,
	output pie_vec_type o_vector,
	output logic o_irq,
	// AXI4-Lite write
	input wire logic i_awvalid,
	input wire logic [7:0] i_awaddr,
	output logic o_awready,
	input wire logic i_wvalid,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	output logic o_wready,
	output logic o_bvalid,
	output logic [1:0] o_bresp,
	input wire logic i_bready,
	// AXI4-Lite read
	input wire logic i_arvalid,
	input wire logic [7:0] i_araddr,
	output logic o_arready,
	output logic o_rvalid,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	input wire logic i_rready
);
	localparam int N = `PIE_NSRC;

	// Source table in priority order
	localparam pie_src_type SRC [0:N-1] = '{
		`PIE_S_RXHI,
		`PIE_S_T2P,
		`PIE_S_T2C,
		`PIE_S_T2U,
		`PIE_S_T2O,
		`PIE_S_T4P,
		`PIE_S_T4C,
		`PIE_S_T4U,
		`PIE_S_T4O,
		`PIE_S_SSP,
		`PIE_S_RXLO,
		`PIE_S_TXLO,
		`PIE_S_CMB,
		`PIE_S_CER,
		`PIE_S_ADC
	};

	// Gathers one flag group into a register word
	function automatic logic [31:0] pack_grp(input logic [N-1:0] v, input logic [1:0] g);
		logic [31:0] r;
		r = 32'h0000_0000;
		for (int i = 0; i < N; i++) begin
			if (SRC[i].grp == g) begin
				r[SRC[i].bitpos] = v[i];
			end
		end
		return r;
	endfunction : pack_grp

	function automatic logic [15:0] lvl_addr(input pie_level_type l);
		logic [15:0] a;
		a = `PIE_PHANTOM;
		unique case (l)
			PIE_LVL_ONE: a = `PIE_ADDR_ONE;
			PIE_LVL_THREE: a = `PIE_ADDR_THREE;
			PIE_LVL_FOUR: a = `PIE_ADDR_FOUR;
			PIE_LVL_FIVE: a = `PIE_ADDR_FIVE;
			PIE_LVL_SIX: a = `PIE_ADDR_SIX;
			default: a = `PIE_PHANTOM;
		endcase
		return a;
	endfunction : lvl_addr

	// Bus state
	logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
	logic [7:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d, wmask;
	logic [3:0] wstrb_q, wstrb_d;
	logic awrdy_q, awrdy_d, wrdy_q, wrdy_d, bvalid_q, bvalid_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic arrdy_q, arrdy_d, rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	logic do_wr, wr_hit;
	// Core state
	logic [N-1:0] pend_q, pend_d, ack_q, ack_d, ena_q, ena_d;
	logic [N-1:0] req_map, here, cand, wclr;
	logic [4:0] mode_q, mode_d;
	logic [2:0] stat_q, stat_d, mask_q, mask_d, ev;
	pie_cpu_lines_type lines_q, lines_d;
	pie_vec_type vec_q, vec_d;
	logic irq_q, irq_d, found;
	logic [3:0] sel;

	assign o_awready = awrdy_q;
	assign o_wready = wrdy_q;
	assign o_bvalid = bvalid_q;
	assign o_bresp = bresp_q;
	assign o_arready = arrdy_q;
	assign o_rvalid = rvalid_q;
	assign o_rdata = rdata_q;
	assign o_rresp = rresp_q;
	assign o_cpu_lines = lines_q;
	assign o_vector = vec_q;
	assign o_irq = irq_q;

	// Write path: address and data taken in either order, then one write
	always_comb begin
		aw_hold_d = aw_hold_q;
		w_hold_d = w_hold_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q && !i_bready;
		bresp_d = bresp_q;
		do_wr = aw_hold_q && w_hold_q && !bvalid_q;
		unique case (awaddr_q)
			`PIE_OFF_PEND0, `PIE_OFF_PEND1, `PIE_OFF_PEND2, `PIE_OFF_MODE,
			`PIE_OFF_ENA, `PIE_OFF_STAT, `PIE_OFF_MASK: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
		if (i_awvalid && awrdy_q) begin
			aw_hold_d = 1'b1;
			awaddr_d = i_awaddr;
		end
		if (i_wvalid && wrdy_q) begin
			w_hold_d = 1'b1;
			wdata_d = i_wdata;
			wstrb_d = i_wstrb;
		end
		if (do_wr) begin
			aw_hold_d = 1'b0;
			w_hold_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = wr_hit ? `PIE_RESP_OKAY : `PIE_RESP_SLVERR;
		end
		awrdy_d = !aw_hold_d;
		wrdy_d = !w_hold_d;
		for (int b = 0; b < 4; b++) begin
			wmask[b*8 +: 8] = {8{wstrb_q[b]}};
		end
	end

	// Read path: one read at a time, answered the cycle after it is taken
	always_comb begin
		rvalid_d = rvalid_q && !i_rready;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (i_arvalid && arrdy_q) begin
			rvalid_d = 1'b1;
			rresp_d = `PIE_RESP_OKAY;
			unique case (i_araddr)
				`PIE_OFF_PEND0: rdata_d = pack_grp(pend_q, `PIE_GRP0);
				`PIE_OFF_PEND1: rdata_d = pack_grp(pend_q, `PIE_GRP1);
				`PIE_OFF_PEND2: rdata_d = pack_grp(pend_q, `PIE_GRP2);
				`PIE_OFF_ACK0: rdata_d = pack_grp(ack_q, `PIE_GRP0);
				`PIE_OFF_ACK1: rdata_d = pack_grp(ack_q, `PIE_GRP1);
				`PIE_OFF_ACK2: rdata_d = pack_grp(ack_q, `PIE_GRP2);
				`PIE_OFF_MODE: rdata_d = {27'h000_0000, mode_q};
				`PIE_OFF_ENA: rdata_d = {17'h0_0000, ena_q};
				`PIE_OFF_STAT: rdata_d = {29'h0000_0000, stat_q};
				`PIE_OFF_MASK: rdata_d = {29'h0000_0000, mask_q};
				`PIE_OFF_LVEC: rdata_d = {16'h0000, vec_q.source_vector_code};
				default: begin
					rdata_d = 32'h0000_0000;
					rresp_d = `PIE_RESP_SLVERR;
				end
			endcase
		end
		arrdy_d = !rvalid_d;
	end

	// Request mapping, mode steering and variant gating
	always_comb begin
		req_map = {
			i_req.converter_done_request && !mode_q[`PIE_MODE_ADC],
			i_req.can_error_request && !mode_q[`PIE_MODE_CAN],
			i_req.can_mailbox_request && !mode_q[`PIE_MODE_CAN],
			i_req.async_transmit_request && !mode_q[`PIE_MODE_TX],
			i_req.async_receive_request && !mode_q[`PIE_MODE_RX],
			i_req.sync_serial_request && !mode_q[`PIE_MODE_SSP],
			i_req.timer_d_overflow_event, i_req.timer_d_underflow_event,
			i_req.timer_d_compare_event, i_req.timer_d_period_event,
			i_req.timer_b_overflow_event, i_req.timer_b_underflow_event,
			i_req.timer_b_compare_event, i_req.timer_b_period_event,
			i_req.async_receive_request && mode_q[`PIE_MODE_RX]};
		here = {
			i_present.converter, {2{i_present.can}}, {2{i_present.async_serial}},
			i_present.sync_serial, {4{i_present.event_manager_second}},
			{4{i_present.event_manager_first}}, i_present.async_serial};
	end

	// Pending, acknowledge and vector answer
	always_comb begin
		pend_d = pend_q;
		ack_d = ack_q;
		mode_d = mode_q;
		ena_d = ena_q;
		mask_d = mask_q;
		vec_d = vec_q;
		vec_d.valid = 1'b0;
		wclr = '0;
		ev = 3'h0;
		// lowest index wins on the level
		for (int i = 0; i < N; i++) begin
			cand[i] = pend_q[i] && ena_q[i] && (SRC[i].level == i_ack_level);
		end
		found = |cand;
		sel = 4'h0;
		for (int i = N - 1; i >= 0; i--) begin
			if (cand[i]) begin
				sel = 4'(i);
			end
		end
		if (i_ack) begin
			vec_d.valid = 1'b1;
			vec_d.addr = lvl_addr(i_ack_level);
			vec_d.phantom = !found;
			ack_d = '0;
			vec_d.source_vector_code = found ? SRC[sel].vec : `PIE_PHANTOM;
			if (found) begin
				ack_d[sel] = 1'b1;
				pend_d[sel] = 1'b0;
			end
			ev[`PIE_ST_PHANTOM] = !found;
			ev[`PIE_ST_SERVED] = found;
		end
		// Software writes, strobes respected
		if (do_wr) begin
			unique case (awaddr_q)
				`PIE_OFF_PEND0: wclr = {N{1'b0}};
				default: wclr = '0;
			endcase
			for (int i = 0; i < N; i++) begin
				if ((awaddr_q == `PIE_OFF_PEND0 && SRC[i].grp == `PIE_GRP0) ||
				    (awaddr_q == `PIE_OFF_PEND1 && SRC[i].grp == `PIE_GRP1) ||
				    (awaddr_q == `PIE_OFF_PEND2 && SRC[i].grp == `PIE_GRP2)) begin
					wclr[i] = wdata_q[SRC[i].bitpos] && wmask[SRC[i].bitpos];
				end
			end
			if (awaddr_q == `PIE_OFF_MODE) begin
				mode_d = (mode_q & ~wmask[4:0]) | (wdata_q[4:0] & wmask[4:0]);
			end
			if (awaddr_q == `PIE_OFF_ENA) begin
				ena_d = (ena_q & ~wmask[N-1:0]) | (wdata_q[N-1:0] & wmask[N-1:0]);
			end
			if (awaddr_q == `PIE_OFF_MASK) begin
				mask_d = (mask_q & ~wmask[2:0]) | (wdata_q[2:0] & wmask[2:0]);
			end
		end
		// Overrun: request onto a flag still pending
		ev[`PIE_ST_LOST] = |(req_map & here & pend_q);
		// A request in the clearing cycle survives
		pend_d = ((pend_d & ~wclr) | req_map) & here;
		ack_d = ack_d & here;
	end

	// Core lines, sticky status and interrupt
	always_comb begin
		lines_d = '0;
		for (int i = 0; i < N; i++) begin
			if (pend_d[i] && ena_d[i]) begin
				unique case (SRC[i].level)
					PIE_LVL_ONE: lines_d.cpu_level_one = 1'b1;
					PIE_LVL_THREE: lines_d.cpu_level_three = 1'b1;
					PIE_LVL_FIVE: lines_d.cpu_level_five = 1'b1;
					PIE_LVL_SIX: lines_d.cpu_level_six = 1'b1;
					default: lines_d.cpu_level_four = 1'b0;
				endcase
			end
		end
		// Set beats write-one-clear
		stat_d = stat_q;
		if (do_wr && awaddr_q == `PIE_OFF_STAT) begin
			stat_d = stat_q & ~(wdata_q[2:0] & wmask[2:0]);
		end
		stat_d = stat_d | ev;
		irq_d = |(stat_d & mask_d);
	end

	// All state frozen while the clock enable is low
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			awrdy_q <= 1'b1;
			wrdy_q <= 1'b1;
			bvalid_q <= 1'b0;
			bresp_q <= `PIE_RESP_OKAY;
			arrdy_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= `PIE_RESP_OKAY;
			pend_q <= '0;
			ack_q <= '0;
			ena_q <= `PIE_ENA_RST;
			mode_q <= `PIE_MODE_RST;
			stat_q <= `PIE_STAT_RST;
			mask_q <= `PIE_MASK_RST;
			lines_q <= '0;
			vec_q <= '0;
			irq_q <= 1'b0;
		end else if (i_clk_en) begin
			aw_hold_q <= aw_hold_d;
			w_hold_q <= w_hold_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			awrdy_q <= awrdy_d;
			wrdy_q <= wrdy_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			arrdy_q <= arrdy_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
			pend_q <= pend_d;
			ack_q <= ack_d;
			ena_q <= ena_d;
			mode_q <= mode_d;
			stat_q <= stat_d;
			mask_q <= mask_d;
			lines_q <= lines_d;
			vec_q <= vec_d;
			irq_q <= irq_d;
		end
	end

	// Checks on routing and acknowledge
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);

	rx_high_route_a: assert property (
		i_clk_en && i_req.async_receive_request && mode_q[`PIE_MODE_RX] &&
		i_present.async_serial && ena_q[`PIE_I_RXHI] && !i_ack
		|=> o_cpu_lines.cpu_level_one && pend_q[`PIE_I_RXHI] &&
		(!pend_q[`PIE_I_RXLO] || $past(pend_q[`PIE_I_RXLO])))
		else $error("high-mode receive not on level one");
	timer_b_route_a: assert property (
		i_clk_en && i_req.timer_b_period_event && i_present.event_manager_first &&
		ena_q[`PIE_I_T2P] && !i_ack
		|=> o_cpu_lines.cpu_level_three && pend_q[`PIE_I_T2P])
		else $error("timer b period not on level three");
	conv_route_a: assert property (
		i_clk_en && i_req.converter_done_request && !mode_q[`PIE_MODE_ADC] &&
		i_present.converter && ena_q[`PIE_I_ADC] && !i_ack
		|=> o_cpu_lines.cpu_level_six)
		else $error("converter done not on level six");
	absent_quiet_a: assert property (
		i_clk_en && !i_present.event_manager_second
		|=> pend_q[`PIE_I_T4P +: 4] == 4'h0 && ack_q[`PIE_I_T4P +: 4] == 4'h0)
		else $error("absent module left a flag");
	timer_d_code_a: assert property (
		i_clk_en && i_ack && i_ack_level == PIE_LVL_THREE && pend_q[`PIE_I_T4P] &&
		ena_q[`PIE_I_T4P] &&
		!(|(pend_q[`PIE_I_T4P-1:`PIE_I_T2P] & ena_q[`PIE_I_T4P-1:`PIE_I_T2P]))
		|=> o_vector.valid && o_vector.source_vector_code == 16'h0039)
		else $error("timer d period code wrong");
	first_wins_a: assert property (
		i_clk_en && i_ack && i_ack_level == PIE_LVL_THREE && pend_q[`PIE_I_T2P] &&
		ena_q[`PIE_I_T2P] && !i_req.timer_b_period_event
		|=> !pend_q[`PIE_I_T2P] && ack_q[`PIE_I_T2P] && $onehot(ack_q))
		else $error("first source not served");
	phantom_code_a: assert property (
		i_clk_en && i_ack && !(|cand)
		|=> o_vector.phantom && o_vector.source_vector_code == `PIE_PHANTOM
		&& stat_q[`PIE_ST_PHANTOM] && ack_q == '0)
		else $error("phantom acknowledge wrong");
	level_addr_a: assert property (
		i_clk_en && i_ack && i_ack_level == PIE_LVL_FIVE
		|=> o_vector.addr == 16'h000A ##1 !o_vector.valid || $past(i_ack))
		else $error("level five vector address wrong");

	phantom_seen_c: cover property (i_clk_en && i_ack && !(|cand));
	level5_served_c: cover property (i_clk_en && i_ack && i_ack_level == PIE_LVL_FIVE && found);
	rx_high_c: cover property (o_cpu_lines.cpu_level_one ##1 o_vector.valid);
endmodule : pie_expander

/* common/pie_cfg.svh */
// Constants of the peripheral interrupt expander: offsets, codes, reset values.
// Assumes pie_pkg is imported wherever this file is included.
// How it works
// - Timer b period: level three, code 002B.
// - Timer b compare: level three, code 002C.
// - Timer b underflow: level three, code 002D.
// - Timer b overflow: level three, code 002E.
// - Timer d period: level three, code 0039.
// - Timer d compare: level three, code 003A.
// - Timer d underflow: level three, code 003B.
// - Timer d overflow: level three, code 003C.
// - Low-mode sync serial: level five, code 0005.
// - Low-mode async receive: level five, code 0006.
// - Low-mode async transmit: level five, code 0007.
// - Low-mode CAN mailbox: level five, code 0040.
// - Low-mode CAN error: level five, code 0041.
// - Low-mode converter done: level six, code 0004.
// - Levels three to six vector addresses fixed.
// - Absent modules never raise anything.
// - High-mode async receive goes to level one.
`ifndef PIE_CFG_SVH
`define PIE_CFG_SVH

`define PIE_NSRC 15
// Register byte offsets
`define PIE_OFF_PEND0 8'h00
`define PIE_OFF_PEND1 8'h04
`define PIE_OFF_PEND2 8'h08
`define PIE_OFF_ACK0 8'h0C
`define PIE_OFF_ACK1 8'h10
`define PIE_OFF_ACK2 8'h14
`define PIE_OFF_MODE 8'h18
`define PIE_OFF_ENA 8'h1C
`define PIE_OFF_STAT 8'h20
`define PIE_OFF_MASK 8'h24
`define PIE_OFF_LVEC 8'h28
// Flag groups and bus answers
`define PIE_GRP0 2'h0
`define PIE_GRP1 2'h1
`define PIE_GRP2 2'h2
`define PIE_RESP_OKAY 2'b00
`define PIE_RESP_SLVERR 2'b10
// Reset values
`define PIE_MODE_RST 5'h00
`define PIE_ENA_RST 15'h7FFF
`define PIE_STAT_RST 3'h0
`define PIE_MASK_RST 3'h0
// Mode bits: set means high-priority mode for RX (level one); set on the others drops the request
`define PIE_MODE_SSP 0
`define PIE_MODE_RX 1
`define PIE_MODE_TX 2
`define PIE_MODE_CAN 3
`define PIE_MODE_ADC 4
// Status bits
`define PIE_ST_PHANTOM 0
`define PIE_ST_SERVED 1
`define PIE_ST_LOST 2
// Codes and core vector addresses
`define PIE_PHANTOM 16'h0000
`define PIE_ADDR_ONE 16'h0002
`define PIE_ADDR_THREE 16'h0006
`define PIE_ADDR_FOUR 16'h0008
`define PIE_ADDR_FIVE 16'h000A
`define PIE_ADDR_SIX 16'h000C
// Source indices, lowest index wins
`define PIE_I_RXHI 0
`define PIE_I_T2P 1
`define PIE_I_T4P 5
`define PIE_I_RXLO 10
`define PIE_I_ADC 14
// Source entries: flag group, bit, level, code
`define PIE_S_RXHI '{`PIE_GRP0, 4'h5, PIE_LVL_ONE, 16'h0006}
`define PIE_S_T2P '{`PIE_GRP1, 4'h0, PIE_LVL_THREE, 16'h002B}
`define PIE_S_T2C '{`PIE_GRP1, 4'h1, PIE_LVL_THREE, 16'h002C}
`define PIE_S_T2U '{`PIE_GRP1, 4'h2, PIE_LVL_THREE, 16'h002D}
`define PIE_S_T2O '{`PIE_GRP1, 4'h3, PIE_LVL_THREE, 16'h002E}
`define PIE_S_T4P '{`PIE_GRP2, 4'h8, PIE_LVL_THREE, 16'h0039}
`define PIE_S_T4C '{`PIE_GRP2, 4'h9, PIE_LVL_THREE, 16'h003A}
`define PIE_S_T4U '{`PIE_GRP2, 4'hA, PIE_LVL_THREE, 16'h003B}
`define PIE_S_T4O '{`PIE_GRP2, 4'hB, PIE_LVL_THREE, 16'h003C}
`define PIE_S_SSP '{`PIE_GRP1, 4'h7, PIE_LVL_FIVE, 16'h0005}
`define PIE_S_RXLO '{`PIE_GRP1, 4'h8, PIE_LVL_FIVE, 16'h0006}
`define PIE_S_TXLO '{`PIE_GRP1, 4'h9, PIE_LVL_FIVE, 16'h0007}
`define PIE_S_CMB '{`PIE_GRP1, 4'hA, PIE_LVL_FIVE, 16'h0040}
`define PIE_S_CER '{`PIE_GRP1, 4'hB, PIE_LVL_FIVE, 16'h0041}
`define PIE_S_ADC '{`PIE_GRP1, 4'hC, PIE_LVL_SIX, 16'h0004}

`endif

/* common/pie_pkg.sv */
// Types of the peripheral interrupt expander.
// Assumes nothing beyond a SystemVerilog tool.
package pie_pkg;
	// CPU maskable levels, valued by level number
	typedef enum logic [2:0] {
		PIE_LVL_NONE = 3'h0,
		PIE_LVL_ONE = 3'h1,
		PIE_LVL_THREE = 3'h3,
		PIE_LVL_FOUR = 3'h4,
		PIE_LVL_FIVE = 3'h5,
		PIE_LVL_SIX = 3'h6
	} pie_level_type;

	// One source: flag group, bit, level, vector code
	typedef struct packed {
		logic [1:0] grp;
		logic [3:0] bitpos;
		pie_level_type level;
		logic [15:0] vec;
	} pie_src_type;

	// Peripheral requests, high while requesting
	typedef struct packed {
		logic timer_b_period_event;
		logic timer_b_compare_event;
		logic timer_b_underflow_event;
		logic timer_b_overflow_event;
		logic timer_d_period_event;
		logic timer_d_compare_event;
		logic timer_d_underflow_event;
		logic timer_d_overflow_event;
		logic sync_serial_request;
		logic async_receive_request;
		logic async_transmit_request;
		logic can_mailbox_request;
		logic can_error_request;
		logic converter_done_request;
	} pie_req_type;

	// Modules fitted in this variant
	typedef struct packed {
		logic event_manager_first;
		logic event_manager_second;
		logic sync_serial;
		logic async_serial;
		logic can;
		logic converter;
	} pie_present_type;

	// Interrupt lines towards the core
	typedef struct packed {
		logic cpu_level_one;
		logic cpu_level_three;
		logic cpu_level_four;
		logic cpu_level_five;
		logic cpu_level_six;
	} pie_cpu_lines_type;

	// Answer to an acknowledge
	typedef struct packed {
		logic valid;
		logic phantom;
		logic [15:0] source_vector_code;
		logic [15:0] addr;
	} pie_vec_type;
endpackage : pie_pkg

/* dv/pie_cpu_model.sv */
// CPU core model: acknowledges one level and collects the vector answer.
// Assumes the expander answers within a few cycles of the acknowledge.
module pie_cpu_model import pie_pkg::*; (
	// Clock and vector from the expander
	input wire logic i_sys_clk,
	input wire pie_vec_type i_vector,
	// Acknowledge towards the expander
	output logic o_ack,
	output pie_level_type o_ack_level
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle at time zero, no level offered
	initial begin
		o_ack = 1'b0;
		o_ack_level = PIE_LVL_NONE;
	end

	// One-cycle acknowledge, then wait a bounded time for the vector
	task automatic acknowledge(input pie_level_type lvl, output pie_vec_type v);
		int n;
		v = '0;
		@(posedge i_sys_clk);
		o_ack <= 1'b1;
		o_ack_level <= lvl;
		@(posedge i_sys_clk);
		o_ack <= 1'b0;
		o_ack_level <= PIE_LVL_NONE; // Level not left showing
		for (n = 0; n < 4; n++) begin
			@(negedge i_sys_clk);
			if (i_vector.valid === 1'b1) begin
				v = i_vector;
				break;
			end
		end
	endtask : acknowledge
endmodule : pie_cpu_model

/* dv/testbench.sv */
// Self-checking bench of the interrupt expander against a queue model.
// Assumes the package, config header and CPU model are compiled first.
`include "pie_cfg.svh"

module testbench import pie_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_sys_clk = 1'b0;
	logic i_resetn = 1'b0;
	pie_req_type i_req = '0;
	pie_present_type i_present = '1;
	logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
	logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
	logic [31:0] i_wdata = 32'h0000_0000;
	logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq, ack;
	logic [1:0] o_bresp, o_rresp;
	logic [31:0] o_rdata;
	pie_level_type ack_lvl;
	pie_cpu_lines_type lines;
	pie_vec_type vec;
	int num_errors = 0;
	int total_checks = 0;
	int pend_q[$];
	logic [15:0] codes [14] = '{16'h002B, 16'h002C, 16'h002D, 16'h002E, 16'h0039, 16'h003A,
		16'h003B, 16'h003C, 16'h0005, 16'h0006, 16'h0007, 16'h0040, 16'h0041, 16'h0004};

	// Clock at 40 MHz
	always #12.5 i_sys_clk = ~i_sys_clk;

	pie_expander i_pie_expander (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_clk_en(1'b1),
		.i_req(i_req), .i_present(i_present), .i_ack(ack), .i_ack_level(ack_lvl),
		.o_cpu_lines(lines), .o_vector(vec), .o_irq(o_irq), .i_awvalid(i_awvalid),
		.i_awaddr(i_awaddr), .o_awready(o_awready), .i_wvalid(i_wvalid), .i_wdata(i_wdata),
		.i_wstrb(4'hF), .o_wready(o_wready), .o_bvalid(o_bvalid), .o_bresp(o_bresp),
		.i_bready(i_bready), .i_arvalid(i_arvalid), .i_araddr(i_araddr),
		.o_arready(o_arready), .o_rvalid(o_rvalid), .o_rdata(o_rdata), .o_rresp(o_rresp),
		.i_rready(i_rready));

	pie_cpu_model i_pie_cpu_model (.i_sys_clk(i_sys_clk), .i_vector(vec), .o_ack(ack),
		.o_ack_level(ack_lvl));

	// Level of a source in request order
	function automatic pie_level_type lvl_of(input int i);
		return (i < 8) ? PIE_LVL_THREE : (i < 13) ? PIE_LVL_FIVE : PIE_LVL_SIX;
	endfunction : lvl_of

	// Core vector address and line pattern of a level
	function automatic logic [20:0] lvl_info(input pie_level_type l);
		case (l)
			PIE_LVL_ONE: return {5'b10000, 16'h0002};
			PIE_LVL_THREE: return {5'b01000, 16'h0006};
			PIE_LVL_FIVE: return {5'b00010, 16'h000A};
			PIE_LVL_SIX: return {5'b00001, 16'h000C};
			default: return {5'b00000, 16'h0008};
		endcase
	endfunction : lvl_info

	// Model acknowledge: lowest index pending on that level, or none
	function automatic int model_ack(input pie_level_type l);
		int best;
		int r;
		best = -1;
		foreach (pend_q[k]) begin
			if (lvl_of(pend_q[k]) == l && (best < 0 || pend_q[k] < pend_q[best])) begin
				best = k;
			end
		end
		if (best < 0) begin
			return -1;
		end
		r = pend_q[best];
		pend_q.delete(best);
		return r;
	endfunction : model_ack

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Write with address and data offered together, response held for
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		bit aw, w;
		logic [1:0] r;
		int n;
		aw = 0;
		w = 0;
		r = 2'b11;
		@(posedge i_sys_clk);
		i_awvalid <= 1'b1;
		i_awaddr <= a;
		i_wvalid <= 1'b1;
		i_wdata <= d;
		i_bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge i_sys_clk);
			if (aw && w && o_bvalid) begin
				r = o_bresp;
				i_bready <= 1'b0;
				break;
			end
			if (!aw && o_awready) begin
				aw = 1;
				i_awvalid <= 1'b0;
			end
			if (!w && o_wready) begin
				w = 1;
				i_wvalid <= 1'b0;
			end
		end
		chk("write response", er, r);
	endtask : wr

	// Read and compare against an expected word and response
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		bit ar;
		logic [31:0] d;
		logic [1:0] r;
		int n;
		ar = 0;
		d = '1;
		r = 2'b11;
		@(posedge i_sys_clk);
		i_arvalid <= 1'b1;
		i_araddr <= a;
		i_rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge i_sys_clk);
			if (ar && o_rvalid) begin
				d = o_rdata;
				r = o_rresp;
				i_rready <= 1'b0;
				break;
			end
			if (!ar && o_arready) begin
				ar = 1;
				i_arvalid <= 1'b0;
			end
		end
		chk("read data", e, d);
		chk("read response", er, r);
	endtask : rd_chk

	// One-cycle request pulse, then look at the lines once it lands
	task automatic pulse(input logic [13:0] r, input logic [4:0] exp_lines);
		@(posedge i_sys_clk);
		i_req <= pie_req_type'(r);
		@(posedge i_sys_clk);
		i_req <= '0;
		@(negedge i_sys_clk);
		chk("level lines", exp_lines, lines);
	endtask : pulse

	// Acknowledge through the CPU model and compare with the queue model
	task automatic do_ack(input pie_level_type l);
		pie_vec_type v;
		int s;
		s = model_ack(l);
		i_pie_cpu_model.acknowledge(l, v);
		chk("vector valid", 1'b1, v.valid);
		chk("vector code", (s < 0) ? 16'h0000 : codes[s], v.source_vector_code);
		chk("phantom flag", (s < 0), v.phantom);
		chk("vector address", lvl_info(l) & 21'h00_FFFF, v.addr);
	endtask : do_ack

	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : stop_test

	// Hang guard, far beyond the few hundred cycles of the tests
	initial begin
		repeat (20000) @(posedge i_sys_clk);
		num_errors++;
		$display("watchdog expired");
		stop_test();
	end

	initial begin
		int a, b, m;
		pie_vec_type v;
		void'($urandom(99));
		repeat (2) @(posedge i_sys_clk);
		i_resetn <= 1'b1;
		// Reset values, mask access, unmapped places
		rd_chk(`PIE_OFF_MODE, 32'h0000_0000, `PIE_RESP_OKAY);
		rd_chk(`PIE_OFF_ENA, 32'h0000_7FFF, `PIE_RESP_OKAY);
		rd_chk(`PIE_OFF_MASK, 32'h0000_0000, `PIE_RESP_OKAY);
		rd_chk(8'h40, 32'h0000_0000, `PIE_RESP_SLVERR);
		wr(8'h44, 32'h0000_0007, `PIE_RESP_SLVERR);
		m = $urandom % 8;
		wr(`PIE_OFF_MASK, m, `PIE_RESP_OKAY);
		rd_chk(`PIE_OFF_MASK, m, `PIE_RESP_OKAY);
		wr(`PIE_OFF_MASK, 32'h0000_0007, `PIE_RESP_OKAY);
		$display("test registers done");
		// Every low-mode source alone: line, code and address
		for (int i = 0; i < 14; i++) begin
			pend_q.push_back(i);
			pulse(14'h2000 >> i, 5'(lvl_info(lvl_of(i)) >> 16)); // ..line
			do_ack(lvl_of(i)); // ..code, address
		end
		$display("test routing done");
		// Two random level-three sources at once, then an empty acknowledge
		a = $urandom % 8;
		b = (a + 1 + $urandom % 7) % 8;
		pend_q.push_back(a);
		pend_q.push_back(b);
		pulse((14'h2000 >> a) | (14'h2000 >> b), 5'b01000);
		do_ack(PIE_LVL_THREE);
		do_ack(PIE_LVL_THREE);
		do_ack(PIE_LVL_THREE);
		rd_chk(`PIE_OFF_STAT, 32'h0000_0003, `PIE_RESP_OKAY);
		wr(`PIE_OFF_MASK, 32'h0000_0000, `PIE_RESP_OKAY);
		repeat (2) @(negedge i_sys_clk);
		chk("irq masked", 1'b0, o_irq);
		wr(`PIE_OFF_MASK, 32'h0000_0001, `PIE_RESP_OKAY);
		repeat (2) @(negedge i_sys_clk);
		chk("irq phantom", 1'b1, o_irq);
		wr(`PIE_OFF_STAT, 32'h0000_0007, `PIE_RESP_OKAY);
		repeat (2) @(negedge i_sys_clk);
		chk("irq cleared", 1'b0, o_irq);
		$display("test priority done");
		// Receive in high mode goes to level one
		wr(`PIE_OFF_MODE, 32'h0000_0002, `PIE_RESP_OKAY);
		pulse(14'h2000 >> 9, 5'b10000);
		i_pie_cpu_model.acknowledge(PIE_LVL_ONE, v);
		chk("high code", 16'h0006, v.source_vector_code);
		chk("high address", 16'h0002, v.addr);
		rd_chk(`PIE_OFF_LVEC, 32'h0000_0006, `PIE_RESP_OKAY);
		rd_chk(`PIE_OFF_ACK0, 32'h0000_0020, `PIE_RESP_OKAY);
		$display("test high mode done");
		// Absent serial module raises nothing
		wr(`PIE_OFF_MODE, 32'h0000_0000, `PIE_RESP_OKAY);
		// No async serial module and no second event manager fitted
		i_present <= pie_present_type'(6'h2B);
		pulse((14'h2000 >> 9) | (14'h2000 >> 4), 5'b00000);
		do_ack(PIE_LVL_FIVE);
		do_ack(PIE_LVL_THREE);
		i_present <= '1;
		$display("test absent done");
		// Software clear of a pending flag, then nothing left to serve
		pulse(14'h2000 >> 13, 5'b00001);
		rd_chk(`PIE_OFF_PEND1, 32'h0000_1000, `PIE_RESP_OKAY);
		wr(`PIE_OFF_PEND1, 32'h0000_1000, `PIE_RESP_OKAY);
		rd_chk(`PIE_OFF_PEND1, 32'h0000_0000, `PIE_RESP_OKAY);
		do_ack(PIE_LVL_SIX);
		$display("test clear done");
		stop_test();
	end
endmodule : testbench
